// ---- verilog/flag_bank_regs.svh ----
`ifndef FLAG_BANK_REGS_SVH
`define FLAG_BANK_REGS_SVH

// Register bus widths
`define ADDR_W 16
`define DATA_W 4
`define REG_COUNT 15
`define REG_IDX_W 4

// Event flag registers, one nibble each
`define RF_FLAGS_ADDR 16'hFFF1
`define TIMER0_FLAGS_ADDR 16'hFFF2
`define TIMER1_FLAGS_ADDR 16'hFFF3
`define TIMER2_FLAGS_ADDR 16'hFFF4
`define TIMER3_FLAGS_ADDR 16'hFFF5
`define TIMER4_FLAGS_ADDR 16'hFFF6
`define TIMER5_FLAGS_ADDR 16'hFFF7
`define TIMER6_FLAGS_ADDR 16'hFFF8
`define TIMER7_FLAGS_ADDR 16'hFFF9
`define SERIAL_FLAGS_ADDR 16'hFFFA
`define KEY_LOW_FLAGS_ADDR 16'hFFFB
`define KEY_HIGH_FLAGS_ADDR 16'hFFFC
`define STOPWATCH_FLAGS_ADDR 16'hFFFD
`define CLOCK_FAST_FLAGS_ADDR 16'hFFFE
`define CLOCK_SLOW_FLAGS_ADDR 16'hFFFF

// Mask bank, same order as the flags, first and last word
`define MASK_FIRST_ADDR 16'hFFE1
`define MASK_LAST_ADDR 16'hFFEF

// Implemented flag bits per register kind; the rest read zero
`define IMPL_RF 4'h7
`define IMPL_TIMER 4'h3
`define IMPL_SERIAL 4'h1
`define IMPL_FULL 4'hF

// Reset values
`define FLAG_RESET 4'h0
`define MASK_RESET 4'h0
`define READ_IDLE 4'h0

`endif

// ---- verilog/flag_bank_pkg.sv ----
package flag_bank_pkg;

    typedef logic [3:0] nibble_t;

    // Register-bus request as seen by the slave
    typedef struct packed {
        logic [15:0] addr;
        nibble_t wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // One-cycle event pulses from the peripheral sources
    typedef struct packed {
        logic rf_error_flag;
        logic rf_reference_done_flag;
        logic rf_sensor_done_flag;
        logic [7:0] timer_underflow_flag;
        logic [7:0] timer_match_flag;
        logic serial_event_flag;
        logic [7:0] key_flag;
        logic stopwatch_run_flag;
        logic stopwatch_lap_flag;
        logic stopwatch_1hz_flag;
        logic stopwatch_10hz_flag;
        logic [7:0] clock_tick_flag;
    } event_t;

    // Which bank an address falls in
    typedef enum logic [1:0] {
        BANK_NONE = 2'b00,
        BANK_FLAG = 2'b01,
        BANK_MASK = 2'b10
    } bank_t;

endpackage

// ---- verilog/flag_nibble.sv ----
`timescale 1ns/1ps
`include "flag_bank_regs.svh"
module flag_nibble
    import flag_bank_pkg::*;
#(
    parameter nibble_t IMPL = `IMPL_FULL
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire nibble_t set_pulse,
    input wire logic clear_wr,
    input wire nibble_t clear_data,
    output nibble_t flags
);

    typedef struct packed {
        nibble_t flags;
    } state_t;

    state_t state_reg;
    state_t state_next;
    nibble_t clear_bits;

    // Set beats clear, so an event in the clearing cycle is kept
    always_comb begin
        state_next = state_reg;
        clear_bits = clear_wr ? clear_data : `FLAG_RESET;
        state_next.flags = (state_reg.flags & ~clear_bits) | set_pulse;
        state_next.flags = state_next.flags & IMPL; // Unused bits stay zero
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg.flags <= `FLAG_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;

endmodule

// ---- verilog/mask_bank.sv ----
`timescale 1ns/1ps
`include "flag_bank_regs.svh"
module mask_bank
    import flag_bank_pkg::*;
#(
    parameter int COUNT = `REG_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wr,
    input wire logic [`REG_IDX_W-1:0] wr_index,
    input wire nibble_t wdata,
    output logic [COUNT-1:0][3:0] masks
);

    typedef struct packed {
        logic [COUNT-1:0][3:0] word;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Plain read/write words; spare bits act as general-purpose storage
    always_comb begin
        state_next = state_reg;
        if (wr) begin
            state_next.word[wr_index] = wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg.word <= {COUNT{`MASK_RESET}};
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign masks = state_reg.word;

endmodule

// ---- verilog/interrupt_factor_flag_bank.sv ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "flag_bank_regs.svh"
// Notes on behaviour
// - Flag reads one after its event occurred.
// - Writing one clears a flag; zero keeps.
// - Reset clears every flag.
// - Converter flags: error, reference, sensor; top zero.
// - Timer registers: underflow D1, match D0.
// - Serial register holds one flag in D0.
// - Key flags 0-3 then 4-7, two registers.
// - Stopwatch: RUN, LAP, 1 Hz, 10 Hz.
// - Clock timer: 16..128 Hz, then 1..8 Hz.
// - Each flag has a separate mask bit.
module interrupt_factor_flag_bank
    import flag_bank_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`ADDR_W-1:0] bus_addr,
    input wire logic [`DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [`DATA_W-1:0] bus_rdata,
    input wire event_t events,
    output logic irq_req,
    output logic [`REG_COUNT-1:0] pending
);

    localparam int COUNT = `REG_COUNT;

    // Register index of each flag word, in address order
    localparam logic [`REG_IDX_W-1:0] IDX_RF = 4'h0;
    localparam logic [`REG_IDX_W-1:0] IDX_SERIAL = 4'h9;
    localparam logic [`REG_IDX_W-1:0] IDX_KEY_LOW = 4'hA;
    localparam logic [`REG_IDX_W-1:0] IDX_KEY_HIGH = 4'hB;
    localparam logic [`REG_IDX_W-1:0] IDX_STOPWATCH = 4'hC;
    localparam logic [`REG_IDX_W-1:0] IDX_CLOCK_FAST = 4'hD;
    localparam logic [`REG_IDX_W-1:0] IDX_CLOCK_SLOW = 4'hE;
    localparam int TIMER_FIRST = 1;

    // All registered state of the top level
    typedef struct packed {
        nibble_t rdata;
        logic irq;
        logic [COUNT-1:0] pending;
    } state_t;

    state_t state_reg;
    state_t state_next;

    bus_req_t req;
    bank_t bank;
    logic [`REG_IDX_W-1:0] index;
    logic [COUNT-1:0][3:0] set_vec;
    logic [COUNT-1:0][3:0] flag_vec;
    logic [COUNT-1:0][3:0] mask_vec;
    logic [COUNT-1:0] flag_wr;
    logic mask_wr;

    // Which bank an address hits; unmapped addresses hit none
    function automatic bank_t bank_of(input logic [`ADDR_W-1:0] a);
        bank_t b;
        b = BANK_NONE;
        if (a >= `RF_FLAGS_ADDR) begin
            b = BANK_FLAG;
        end else if (a >= `MASK_FIRST_ADDR && a <= `MASK_LAST_ADDR) begin
            b = BANK_MASK;
        end
        return b;
    endfunction

    // Word index inside a bank; both banks share the same order
    function automatic logic [`REG_IDX_W-1:0] index_of(
        input logic [`ADDR_W-1:0] a,
        input bank_t b
    );
        logic [`ADDR_W-1:0] d;
        d = '0;
        if (b == BANK_FLAG) begin
            d = a - `RF_FLAGS_ADDR;
        end else if (b == BANK_MASK) begin
            d = a - `MASK_FIRST_ADDR;
        end
        return d[`REG_IDX_W-1:0];
    endfunction

    // Bit layout of each flag word in the bank
    function automatic nibble_t impl_of(input int i);
        nibble_t m;
        m = `IMPL_FULL;
        if (i == int'(IDX_RF)) begin
            m = `IMPL_RF;
        end else if (i == int'(IDX_SERIAL)) begin
            m = `IMPL_SERIAL;
        end else if (i >= TIMER_FIRST && i < int'(IDX_SERIAL)) begin
            m = `IMPL_TIMER;
        end
        return m;
    endfunction

    // Gather the bus signals into one request
    always_comb begin
        req.addr = bus_addr;
        req.wdata = bus_wdata;
        req.wr = bus_wr;
        req.rd = bus_rd;
        bank = bank_of(req.addr);
        index = index_of(req.addr, bank);
        mask_wr = req.wr && (bank == BANK_MASK);
    end

    // Route event pulses into their flag words; unused upper bits of the converter, timer and serial words stay zero
    always_comb begin
        set_vec = '0;
        // Error D2, reference done D1, sensor done D0
        set_vec[IDX_RF] = {1'b0, events.rf_error_flag,
                           events.rf_reference_done_flag,
                           events.rf_sensor_done_flag};
        // One word per programmable timer, underflow above match
        for (int t = 0; t < 8; t++) begin
            set_vec[TIMER_FIRST + t] = {2'b00, events.timer_underflow_flag[t],
                                        events.timer_match_flag[t]};
        end
        set_vec[IDX_SERIAL] = {3'b000, events.serial_event_flag};
        // Port-one keys first, then the port-four keys
        set_vec[IDX_KEY_LOW] = events.key_flag[3:0];
        set_vec[IDX_KEY_HIGH] = events.key_flag[7:4];
        set_vec[IDX_STOPWATCH] = {events.stopwatch_run_flag,
                                  events.stopwatch_lap_flag,
                                  events.stopwatch_1hz_flag,
                                  events.stopwatch_10hz_flag};
        // Tick bit 0 is 128 Hz rising to bit 7 at 1 Hz
        set_vec[IDX_CLOCK_FAST] = events.clock_tick_flag[3:0];
        set_vec[IDX_CLOCK_SLOW] = events.clock_tick_flag[7:4];
    end

    // Clear strobe for the one flag word that a write addresses
    always_comb begin
        flag_wr = '0;
        if (req.wr && bank == BANK_FLAG) begin
            flag_wr[index] = 1'b1;
        end
    end

    // One nibble of flags per register, layout fixed per word
    for (genvar g = 0; g < COUNT; g++) begin : g_flag
        flag_nibble #(
            .IMPL(impl_of(g))
        ) u_flag (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .set_pulse(set_vec[g]),
            .clear_wr(flag_wr[g]),
            .clear_data(req.wdata),
            .flags(flag_vec[g])
        );
    end

    // Enable bits, one word per flag word
    mask_bank #(
        .COUNT(COUNT)
    ) u_mask (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr(mask_wr),
        .wr_index(index),
        .wdata(req.wdata),
        .masks(mask_vec)
    );

    // Read data for the next cycle, request from flags and masks.
    // The request follows the flags with one cycle of lag, since every
    // output must come from a flop; a cleared flag drops it a cycle late.
    always_comb begin
        state_next = state_reg;
        state_next.rdata = `READ_IDLE;
        if (req.rd) begin
            if (bank == BANK_FLAG) begin
                state_next.rdata = flag_vec[index];
            end else if (bank == BANK_MASK) begin
                state_next.rdata = mask_vec[index];
            end
        end
        for (int i = 0; i < COUNT; i++) begin
            state_next.pending[i] = |(flag_vec[i] & mask_vec[i]);
        end
        state_next.irq = |state_next.pending;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg.rdata <= `READ_IDLE;
            state_reg.irq <= 1'b0;
            state_reg.pending <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign bus_rdata = state_reg.rdata;
    assign irq_req = state_reg.irq;
    assign pending = state_reg.pending;

endmodule

// ---- sim/interrupt_factor_flag_bank_checker.sv ----
`timescale 1ns/1ps
`include "flag_bank_regs.svh"
module interrupt_factor_flag_bank_checker
    import flag_bank_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`ADDR_W-1:0] bus_addr,
    input wire logic [`DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [`DATA_W-1:0] bus_rdata,
    input wire event_t events,
    input wire logic irq_req,
    input wire logic [`REG_COUNT-1:0] pending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic rd_ok;
    logic ser;
    // Reads only count when the enable lets the edge act
    assign rd_ok = bus_rd && clk_en;
    assign ser = bus_addr == `SERIAL_FLAGS_ADDR;
    // Read data stands one cycle only, zero otherwise; a frozen cycle keeps it
    a_rdata_idle: assert property (clk_en && !bus_rd |=> bus_rdata == `READ_IDLE)
        else $error("read data not idle");
    a_rf_top_zero: assert property (
        rd_ok && bus_addr == `RF_FLAGS_ADDR |=> !bus_rdata[3])
        else $error("converter top bit set");
    a_timer_top_zero: assert property (
        rd_ok && bus_addr inside {[`TIMER0_FLAGS_ADDR:`TIMER7_FLAGS_ADDR]}
        |=> bus_rdata[3:2] == 2'h0)
        else $error("timer unused bits set");
    a_serial_top_zero: assert property (rd_ok && ser |=> bus_rdata[3:1] == 3'h0)
        else $error("serial unused bits set");
    a_irq_matches_pending: assert property (irq_req == (|pending))
        else $error("request differs from pending words");
    a_reset_clears: assert property ($rose(rst_n) |-> !irq_req && pending == 15'h0)
        else $error("state not clear after reset");
    a_event_sets: assert property (
        clk_en && events.serial_event_flag ##1 rd_ok && ser |=> bus_rdata[0])
        else $error("event did not set flag");
    a_write_clears: assert property (
        clk_en && bus_wr && ser && bus_wdata[0] && !events.serial_event_flag
        ##1 rd_ok && ser && !events.serial_event_flag |=> !bus_rdata[0])
        else $error("write of one did not clear");
    a_unmapped_zero: assert property (rd_ok && bus_addr == 16'hFFF0 |=> bus_rdata == 4'h0)
        else $error("unmapped read not zero");
endmodule
bind interrupt_factor_flag_bank interrupt_factor_flag_bank_checker u_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .events(events), .irq_req(irq_req), .pending(pending)
);

// ---- sim/flag_event_source.sv ----
`timescale 1ns/1ps
module flag_event_source
    import flag_bank_pkg::*;
(
    input wire logic go,
    input wire logic [5:0] sel,
    output event_t events
);
    logic [$bits(event_t)-1:0] vec;
    // One source pulses per request; idle sources stay low like the real ones
    always_comb begin
        vec = '0;
        if (go) begin
            vec[sel] = 1'h1;
        end
    end
    assign events = event_t'(vec);
endmodule

// ---- sim/test_interrupt_factor_flag_bank.sv ----
`timescale 1ns/1ps
`include "flag_bank_regs.svh"
module test_interrupt_factor_flag_bank
    import flag_bank_pkg::*;
;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic clk_en = 1'h1;
    logic [15:0] bus_addr = 16'h0;
    logic [3:0] bus_wdata = 4'h0;
    logic bus_wr = 1'h0;
    logic bus_rd = 1'h0;
    logic [3:0] bus_rdata;
    event_t events;
    logic irq_req;
    logic [14:0] pending;
    logic go = 1'h0;
    logic [5:0] sel = 6'h0;
    int n_mismatch = 0;
    int checks_done = 0;
    // 125 MHz
    always #4 ref_clk = ~ref_clk;
    interrupt_factor_flag_bank u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .events(events), .irq_req(irq_req), .pending(pending));
    flag_event_source u_src (.go(go), .sel(sel), .events(events));
    // Shared compare, hex report on mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus tasks are entered at an edge and return at an edge
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'h1;
        @(posedge ref_clk);
        bus_wr <= 1'h0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [3:0] exp);
        bus_addr <= a;
        bus_rd <= 1'h1;
        @(posedge ref_clk);
        bus_rd <= 1'h0;
        #1 chk(16'(bus_rdata), 16'(exp));
        @(posedge ref_clk);
    endtask
    task automatic fire(input int i);
        sel <= 6'(i);
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
    endtask
    // Flag word and bit that event bit i must land in
    function automatic logic [15:0] word_of(input int i);
        return i < 4 ? `CLOCK_FAST_FLAGS_ADDR : i < 8 ? `CLOCK_SLOW_FLAGS_ADDR :
            i < 12 ? `STOPWATCH_FLAGS_ADDR : i < 16 ? `KEY_LOW_FLAGS_ADDR :
            i < 20 ? `KEY_HIGH_FLAGS_ADDR : i == 20 ? `SERIAL_FLAGS_ADDR :
            i < 29 ? `TIMER0_FLAGS_ADDR + 16'(i - 21) :
            i < 37 ? `TIMER0_FLAGS_ADDR + 16'(i - 29) : `RF_FLAGS_ADDR;
    endfunction
    function automatic int bit_of(input int i);
        return i < 20 ? i % 4 : i < 29 ? 0 : i < 37 ? 1 : i - 37;
    endfunction
    // Every source: set unmasked, unmask, write zeros, clear
    task automatic test_events();
        logic [15:0] a;
        logic [3:0] m;
        for (int i = 0; i < $bits(event_t); i++) begin
            a = word_of(i);
            m = 4'h1 << bit_of(i);
            fire(i);
            rdchk(a, m);
            #1 chk(16'(irq_req), 16'h0);
            @(posedge ref_clk);
            wr(a - 16'h0010, m);
            rdchk(a - 16'h0010, m);
            #1 chk(16'(pending), 16'h1 << (a - `RF_FLAGS_ADDR));
            chk(16'(irq_req), 16'h1);
            @(posedge ref_clk);
            wr(a, ~m);
            rdchk(a, m);
            wr(a, m);
            rdchk(a, 4'h0);
            #1 chk(16'(irq_req), 16'h0);
            @(posedge ref_clk);
            wr(a - 16'h0010, 4'h0);
        end
        $display("events test done");
    endtask
    // Enable low: the event and the mask write of those cycles are dropped
    task automatic test_enable();
        clk_en <= 1'h0;
        fire(20);
        wr(`SERIAL_FLAGS_ADDR - 16'h0010, 4'h1);
        clk_en <= 1'h1;
        rdchk(`SERIAL_FLAGS_ADDR, 4'h0);
        rdchk(`SERIAL_FLAGS_ADDR - 16'h0010, 4'h0);
        $display("enable test done");
    endtask
    // Reset in mid-run with flags and a mask set
    task automatic test_reset();
        fire(39);
        @(posedge ref_clk);
        fire(0);
        wr(`MASK_FIRST_ADDR, 4'h7);
        @(posedge ref_clk);
        #1 chk(16'(pending), 16'h1);
        @(posedge ref_clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        for (int k = 0; k < 15; k++) begin
            rdchk(`RF_FLAGS_ADDR + 16'(k), 4'h0);
            rdchk(`MASK_FIRST_ADDR + 16'(k), 4'h0);
        end
        wr(16'hFFF0, 4'hF);
        rdchk(16'hFFF0, 4'h0);
        $display("reset test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence after the 20-cycle reset
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        test_events();
        test_enable();
        test_reset();
        finish_test();
    end
    // Watchdog well past the expected length of the run
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
endmodule
